// >>> verilog/aon_regs_pkg.sv
// Behaviour
// [R1] Wake-cause bits 11:8 read which converter sensor pin 0-3 woke the chip.
// [R2] Seven wake flags, gpio at bit 6 down to external pins at bit 0.
// [R3] Writing 1 clears a wake flag; writing 0 leaves it armed.
// [R4] Any external wake pin event sets the external wake flag.
// [R5] 36-bit free-running counter read as low word and four high bits.
// [R6] Ready flags for supplies and crystals at bits 13:8 and bit 3.
// [R7] Status bit 0 reads the primary external wake pin level.
// [R8] Supply-drop bits 14 and 13 report brownout and blackout events.
// [R9] Brownout threshold, bits 7:4, read-write, resets to 0111.
// [R10] Blackout threshold, bits 3:0, read-write, resets to 0101.
// [R11] Hysteresis selects at bits 12 and 11: 0 is 100 mV, 1 is 150 mV.
// [R12] Tap field 4:0 picks counter bit 35..14 clocking the watchdog count.
// [R13] Watchdog count readable at bits 6:5.
// [R14] Converter resolution at bits 15:14, codes 3..0 give 12,10,6,4 bits.
// [R15] Channel select at bits 3:2 picks input 0 to 3, resets to 0.
// [R16] Channel 0 condition bits 13:12: over, under, difference, 3 reserved.
// [R17] Channel 1 condition bits 29:28 with the same encoding.
// [R18] Thresholds 12-bit read-write at 11:0 and 27:16, reset zero.
// [R19] Power switch bit 4 powers the one-time memory, resets to 1.
// [R20] Power switch bit 3 flags one-time memory supply stable, resets to 1.
// [R21] Power switch bit 5 turns the retention supply on, resets to 0.
// [R22] Power switch bit 2 enables the PLL supply, resets to 0.
// [R23] Power switch register sits just below the reserved slot before wake cause.
// [R24] Reads have no side effects; only 1-writes change wake flags.
package aon_regs_pkg;

  // ********************************************************
  // Register map
  // ********************************************************
  localparam logic [31:0] ADDR_PWR_SW = 32'h5009_1020;
  localparam logic [31:0] ADDR_WAKE = 32'h5009_1028;
  localparam logic [31:0] ADDR_CNT_LO = 32'h5009_1038;
  localparam logic [31:0] ADDR_CNT_HI = 32'h5009_103c;
  localparam logic [31:0] ADDR_READY = 32'h5009_1040;
  localparam logic [31:0] ADDR_TUNE = 32'h5009_1044;
  localparam logic [31:0] ADDR_DROP = 32'h5009_104c;
  localparam logic [31:0] ADDR_WDOG = 32'h5009_105c;
  localparam logic [31:0] ADDR_CONV = 32'h5009_1060;
  localparam logic [31:0] ADDR_THR = 32'h5009_1064;

  // ********************************************************
  // Reset values and writable masks
  // ********************************************************
  localparam logic [9:0] PWR_SW_RST = 10'h0d8;
  localparam logic [9:0] PWR_SW_MASK = 10'h3fd;
  localparam logic [29:0] TUNE_RST = 30'h0b03_1710;
  localparam logic [29:0] TUNE_MASK = 30'h3f3f_fff3;
  localparam logic [12:0] DROP_RST = 13'h0075;
  localparam logic [4:0] WDOG_TAP_RST = 5'h00;
  localparam logic [15:0] CONV_RST = 16'h0001;
  localparam logic [29:0] THR_RST = 30'h0000_0000;

  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int WAKE_SENSOR_LSB = 8;
  localparam int WAKE_FLAGS_W = 7;
  localparam int READY_HI_LSB = 8;
  localparam int READY_SLOW_XTAL_BIT = 3;
  localparam int READY_PIN_BIT = 0;
  localparam int DROP_BLACK_BIT = 13;
  localparam int WDOG_CNT_LSB = 5;
  localparam int WDOG_TAP_BASE = 14;
  localparam int WDOG_TAP_SPAN = 22;
  localparam int RTC_W = 36;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ********************************************************
  // Carriers
  // ********************************************************
  typedef struct packed {
    logic gpio;
    logic pulse;
    logic sensor;
    logic watchdog;
    logic por;
    logic compare;
    logic ext;
  } wake_evt_s;

  typedef struct packed {
    logic ip1_supply_ready;
    logic dcdc_ready;
    logic flash_supply_ready;
    logic digital_supply_ready;
    logic radio_supply_ready;
    logic fast_crystal_ready;
    logic slow_crystal_ready;
  } ready_s;

  typedef struct packed {
    logic ip1_supply_on;
    logic radio_supply_on;
    logic digital_supply_on;
    logic dcdc_xtal_on;
    logic retention_supply_on;
    logic otp_supply_switch;
    logic otp_supply_stable;
    logic pll_supply_on;
    logic rsvd;
    logic xtal_noise_reduce;
  } pwr_sw_s;

  typedef struct packed {
    logic brown_hysteresis_sel;
    logic black_hysteresis_sel;
    logic rsvd;
    logic brown_enable;
    logic black_enable;
    logic [3:0] brown_threshold;
    logic [3:0] black_threshold;
  } drop_cfg_s;

  typedef struct packed {
    logic [1:0] conv_resolution;
    logic [1:0] ref_trim;
    logic [1:0] comp_sel;
    logic [1:0] comp_trim;
    logic settle_en;
    logic [2:0] trim;
    logic [1:0] conv_channel;
    logic power_on;
    logic conv_reset;
  } conv_ctrl_s;

  typedef struct packed {
    logic [1:0] ch1_cond;
    logic [11:0] ch1_level;
    logic [1:0] rsvd;
    logic [1:0] ch0_cond;
    logic [11:0] ch0_level;
  } thr_s;

endpackage

// >>> verilog/aon_power_wake_regs.sv
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
module aon_power_wake_regs (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire aon_regs_pkg::wake_evt_s wake_evt,
  input wire logic [4:0] ext_wake_pins,
  input wire logic [3:0] sensor_wake_pins,
  input wire logic ext_wake_level,
  input wire aon_regs_pkg::ready_s ready_in,
  input wire logic brown_event,
  input wire logic black_event,
  input wire logic wdog_count_en,
  output aon_regs_pkg::pwr_sw_s pwr_sw,
  output logic [29:0] regulator_tuning,
  output aon_regs_pkg::drop_cfg_s drop_cfg,
  output logic [4:0] wdog_tap,
  output logic [1:0] wdog_count,
  output aon_regs_pkg::conv_ctrl_s conv_ctrl,
  output aon_regs_pkg::thr_s conv_thr,
  output logic [35:0] rtc_count
);

  // ********************************************************
  // Write channel capture
  // ********************************************************
  logic aw_held_r;
  logic [31:0] aw_addr_r;
  logic w_held_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;

  wire aw_take = s_axi_awvalid & ~aw_held_r;
  wire w_take = s_axi_wvalid & ~w_held_r;
  // Response stalls the commit so at most one write is open
  wire do_write = aw_held_r & w_held_r & ~bvalid_r;

  assign s_axi_awready = ~aw_held_r;
  assign s_axi_wready = ~w_held_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  wire [31:0] byte_mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                           {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  wire [31:0] wr_bits = w_data_r & byte_mask;

  // [R23] Power switch decode
  wire wr_pwr = do_write & (aw_addr_r == aon_regs_pkg::ADDR_PWR_SW);
  wire wr_wake = do_write & (aw_addr_r == aon_regs_pkg::ADDR_WAKE);
  wire wr_tune = do_write & (aw_addr_r == aon_regs_pkg::ADDR_TUNE);
  wire wr_drop = do_write & (aw_addr_r == aon_regs_pkg::ADDR_DROP);
  wire wr_wdog = do_write & (aw_addr_r == aon_regs_pkg::ADDR_WDOG);
  wire wr_conv = do_write & (aw_addr_r == aon_regs_pkg::ADDR_CONV);
  wire wr_thr = do_write & (aw_addr_r == aon_regs_pkg::ADDR_THR);
  wire wr_ro = (aw_addr_r == aon_regs_pkg::ADDR_CNT_LO) |
               (aw_addr_r == aon_regs_pkg::ADDR_CNT_HI) |
               (aw_addr_r == aon_regs_pkg::ADDR_READY);
  wire wr_hit = (aw_addr_r == aon_regs_pkg::ADDR_PWR_SW) |
                (aw_addr_r == aon_regs_pkg::ADDR_WAKE) |
                (aw_addr_r == aon_regs_pkg::ADDR_TUNE) |
                (aw_addr_r == aon_regs_pkg::ADDR_DROP) |
                (aw_addr_r == aon_regs_pkg::ADDR_WDOG) |
                (aw_addr_r == aon_regs_pkg::ADDR_CONV) |
                (aw_addr_r == aon_regs_pkg::ADDR_THR) | wr_ro;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 32'h0000_0000;
    end else if (aw_take) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (w_take) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  // Read-only registers accept writes silently; only holes answer with an error
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r <= aon_regs_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? aon_regs_pkg::RESP_OKAY : aon_regs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ********************************************************
  // Control registers
  // ********************************************************
  logic [9:0] pwr_sw_r;
  logic [29:0] tune_r;
  logic [12:0] drop_r;
  logic [4:0] tap_r;
  logic [15:0] conv_r;
  logic [29:0] thr_r;

  // [R19] [R20] [R21] [R22] Switches keep reserved bit 1 at zero
  wire [9:0] pwr_sw_nxt = (pwr_sw_r & ~(byte_mask[9:0] & aon_regs_pkg::PWR_SW_MASK)) |
                          (wr_bits[9:0] & aon_regs_pkg::PWR_SW_MASK);
  wire [29:0] tune_nxt = (tune_r & ~(byte_mask[29:0] & aon_regs_pkg::TUNE_MASK)) |
                         (wr_bits[29:0] & aon_regs_pkg::TUNE_MASK);
  // [R9] [R10] [R11] Detector settings
  wire [12:0] drop_nxt = (drop_r & ~byte_mask[12:0]) | wr_bits[12:0];
  // [R12] Tap select
  wire [4:0] tap_nxt = (tap_r & ~byte_mask[4:0]) | wr_bits[4:0];
  // [R14] [R15] Converter control
  wire [15:0] conv_nxt = (conv_r & ~byte_mask[15:0]) | wr_bits[15:0];
  // [R16] [R17] [R18] Thresholds and conditions
  wire [29:0] thr_nxt = (thr_r & ~byte_mask[29:0]) | wr_bits[29:0];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwr_sw_r <= aon_regs_pkg::PWR_SW_RST;
      tune_r <= aon_regs_pkg::TUNE_RST;
      drop_r <= aon_regs_pkg::DROP_RST;
      tap_r <= aon_regs_pkg::WDOG_TAP_RST;
      conv_r <= aon_regs_pkg::CONV_RST;
      thr_r <= aon_regs_pkg::THR_RST;
    end else begin
      if (wr_pwr) pwr_sw_r <= pwr_sw_nxt;
      if (wr_tune) tune_r <= tune_nxt;
      if (wr_drop) drop_r <= drop_nxt;
      if (wr_wdog) tap_r <= tap_nxt;
      if (wr_conv) conv_r <= conv_nxt;
      if (wr_thr) thr_r <= thr_nxt;
    end
  end

  assign pwr_sw = pwr_sw_r;
  assign regulator_tuning = tune_r;
  assign drop_cfg = drop_r;
  assign wdog_tap = tap_r;
  assign conv_ctrl = conv_r;
  assign conv_thr = thr_r;

  // ********************************************************
  // Wake cause flags
  // ********************************************************
  logic [6:0] wake_r;

  // [R4] Any dedicated pin wakes through the same flag
  wire [6:0] wake_set = {wake_evt.gpio, wake_evt.pulse, wake_evt.sensor,
                         wake_evt.watchdog, wake_evt.por, wake_evt.compare,
                         wake_evt.ext | (|ext_wake_pins)};
  // [R3] Only ones written clear
  wire [6:0] wake_clr = wr_wake ? wr_bits[6:0] : 7'h00;
  // [R2] [R24] Event in the clearing cycle survives
  wire [6:0] wake_nxt = (wake_r & ~wake_clr) | wake_set;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wake_r <= 7'h00;
    end else begin
      wake_r <= wake_nxt;
    end
  end

  // ********************************************************
  // Free-running counter and watchdog tap
  // ********************************************************
  logic [aon_regs_pkg::RTC_W-1:0] rtc_r;
  logic tap_prev_r;
  logic [1:0] wdog_cnt_r;

  // [R5] Counter runs from reset without software
  wire [aon_regs_pkg::RTC_W-1:0] rtc_nxt = rtc_r + 36'h0_0000_0001;
  wire [aon_regs_pkg::WDOG_TAP_SPAN-1:0] tap_bits =
    rtc_r[aon_regs_pkg::RTC_W-1:aon_regs_pkg::WDOG_TAP_BASE];
  // Codes beyond the top counter bit select nothing and freeze the count
  wire tap_valid = (tap_r < 5'(aon_regs_pkg::WDOG_TAP_SPAN));
  wire tap_level = tap_valid & tap_bits[tap_r];
  // [R12] Rising edge of the selected bit clocks the count
  wire tap_tick = tap_level & ~tap_prev_r & wdog_count_en;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rtc_r <= 36'h0_0000_0000;
      tap_prev_r <= 1'b0;
      wdog_cnt_r <= 2'b00;
    end else begin
      rtc_r <= rtc_nxt;
      tap_prev_r <= tap_level;
      if (tap_tick) wdog_cnt_r <= wdog_cnt_r + 2'b01;
    end
  end

  assign rtc_count = rtc_r;
  assign wdog_count = wdog_cnt_r;

  // ********************************************************
  // Read path
  // ********************************************************
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  wire ar_take = s_axi_arvalid & ~rvalid_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  wire rd_pwr = (s_axi_araddr == aon_regs_pkg::ADDR_PWR_SW);
  wire rd_wake = (s_axi_araddr == aon_regs_pkg::ADDR_WAKE);
  wire rd_lo = (s_axi_araddr == aon_regs_pkg::ADDR_CNT_LO);
  wire rd_hi = (s_axi_araddr == aon_regs_pkg::ADDR_CNT_HI);
  wire rd_rdy = (s_axi_araddr == aon_regs_pkg::ADDR_READY);
  wire rd_tune = (s_axi_araddr == aon_regs_pkg::ADDR_TUNE);
  wire rd_drop = (s_axi_araddr == aon_regs_pkg::ADDR_DROP);
  wire rd_wdog = (s_axi_araddr == aon_regs_pkg::ADDR_WDOG);
  wire rd_conv = (s_axi_araddr == aon_regs_pkg::ADDR_CONV);
  wire rd_thr = (s_axi_araddr == aon_regs_pkg::ADDR_THR);
  wire rd_hit = rd_pwr | rd_wake | rd_lo | rd_hi | rd_rdy | rd_tune |
                rd_drop | rd_wdog | rd_conv | rd_thr;

  // [R1] [R2] Sensor pins and sticky flags
  wire [31:0] wake_word = {20'h0_0000, sensor_wake_pins, 1'b0, wake_r};
  // [R6] [R7] Ready flags and wake pin level
  wire [31:0] ready_word = {18'h0_0000, ready_in.ip1_supply_ready, ready_in.dcdc_ready,
                            ready_in.flash_supply_ready, ready_in.digital_supply_ready,
                            ready_in.radio_supply_ready, ready_in.fast_crystal_ready,
                            4'h0, ready_in.slow_crystal_ready, 2'b00, ext_wake_level};
  // [R8] Detector events
  wire [31:0] drop_word = {17'h0_0000, brown_event, black_event, drop_r};
  // [R13] Watchdog count beside the tap
  wire [31:0] wdog_word = {25'h000_0000, wdog_cnt_r, tap_r};
  // [R5] Counter halves
  wire [31:0] lo_word = rtc_r[31:0];
  wire [31:0] hi_word = {28'h000_0000, rtc_r[aon_regs_pkg::RTC_W-1:32]};

  wire [31:0] rd_word =
    rd_pwr ? {22'h00_0000, pwr_sw_r} :
    rd_wake ? wake_word :
    rd_lo ? lo_word :
    rd_hi ? hi_word :
    rd_rdy ? ready_word :
    rd_tune ? {2'b00, tune_r} :
    rd_drop ? drop_word :
    rd_wdog ? wdog_word :
    rd_conv ? {16'h0000, conv_r} :
    rd_thr ? {2'b00, thr_r} : 32'h0000_0000;

  // [R24] Reads only sample, nothing is cleared
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= aon_regs_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_hit ? aon_regs_pkg::RESP_OKAY : aon_regs_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule

// >>> verification/aon_power_wake_regs_properties.sv
`timescale 1ns/10ps
module aon_power_wake_regs_checker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic ext_wake_level,
  input wire logic [3:0] sensor_wake_pins,
  input wire aon_regs_pkg::ready_s ready_in,
  input wire logic brown_event,
  input wire logic black_event,
  input wire aon_regs_pkg::pwr_sw_s pwr_sw,
  input wire aon_regs_pkg::drop_cfg_s drop_cfg,
  input wire logic [35:0] rtc_count
);
  // ********************************************************
  // Read data follows the live sources at the accept edge; counter step and reset values
  // ********************************************************
  logic ar_hs;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_count_step: assert property (
    1'b1 |=> rtc_count == $past(rtc_count) + 36'd1) else $error("counter missed a step");
  a_count_read: assert property (
    ar_hs && s_axi_araddr == aon_regs_pkg::ADDR_CNT_LO |=> s_axi_rdata == $past(rtc_count[31:0]))
    else $error("low count read wrong");
  a_pin_live: assert property (
    ar_hs && s_axi_araddr == aon_regs_pkg::ADDR_READY |=> s_axi_rdata[0] == $past(ext_wake_level))
    else $error("wake pin level read wrong");
  a_ready_live: assert property (
    ar_hs && s_axi_araddr == aon_regs_pkg::ADDR_READY
    |=> s_axi_rdata[13:8] == $past(ready_in[6:1]) && s_axi_rdata[3] == $past(ready_in[0]))
    else $error("ready flags read wrong");
  a_sensor_live: assert property (
    ar_hs && s_axi_araddr == aon_regs_pkg::ADDR_WAKE
    |=> s_axi_rdata[11:8] == $past(sensor_wake_pins)) else $error("sensor pins read wrong");
  a_drop_status: assert property (
    ar_hs && s_axi_araddr == aon_regs_pkg::ADDR_DROP
    |=> s_axi_rdata[14:13] == {$past(brown_event), $past(black_event)})
    else $error("supply drop status wrong");
  a_switch_reset: assert property (
    $rose(rst_n) |-> pwr_sw == 10'h0d8) else $error("power switch reset value wrong");
  a_drop_reset: assert property (
    $rose(rst_n) |-> drop_cfg == 13'h0075) else $error("detector reset value wrong");
endmodule

bind aon_power_wake_regs aon_power_wake_regs_checker checker_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .ext_wake_level(ext_wake_level), .sensor_wake_pins(sensor_wake_pins), .ready_in(ready_in),
  .brown_event(brown_event), .black_event(black_event), .pwr_sw(pwr_sw),
  .drop_cfg(drop_cfg), .rtc_count(rtc_count)
);

// >>> verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic clk_sys, rst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, brown_event = 1'b0, black_event = 1'b0;
  logic wdog_count_en = 1'b0, ext_wake_level = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, sensor_wake_pins = 4'h0;
  logic [4:0] ext_wake_pins = 5'h00;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  aon_regs_pkg::wake_evt_s wake_evt = 7'h00;
  aon_regs_pkg::ready_s ready_in = 7'h00;
  logic [29:0] tune_o, thr_o;
  logic [1:0] wcnt_o;
  int err_total = 0, comparisons = 0, cyc = 0, last_t = 0;

  aon_power_wake_regs aon_power_wake_regs_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .wake_evt(wake_evt), .ext_wake_pins(ext_wake_pins),
    .sensor_wake_pins(sensor_wake_pins), .ext_wake_level(ext_wake_level), .ready_in(ready_in),
    .brown_event(brown_event), .black_event(black_event), .wdog_count_en(wdog_count_en),
    .pwr_sw(), .regulator_tuning(tune_o), .drop_cfg(), .wdog_tap(), .wdog_count(wcnt_o),
    .conv_ctrl(), .conv_thr(thr_o), .rtc_count()
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;

  // ********************************************************
  // Bus tasks
  // ********************************************************
  task automatic report_and_stop();
    $display("Counts: comparisons=%0d mismatches=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic hang();
    err_total++;
    $display("Bus answer never came at t=%0t", $time);
    report_and_stop();
  endtask

  // Ready lines stay high, so no task re-drives them in one step
  task automatic wc(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ha, hw, hb;
    logic [1:0] r;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge clk_sys);
      ha = s_axi_awvalid & s_axi_awready;
      hw = s_axi_wvalid & s_axi_wready;
      hb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk_sys);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) begin
        chk({r, 32'h0}, {er, 32'h0});
        return;
      end
    end
    hang();
  endtask

  task automatic rd(input logic [31:0] a, output logic [33:0] v);
    logic ha, hr;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge clk_sys);
      ha = s_axi_arvalid & s_axi_arready;
      hr = s_axi_rvalid;
      v = {s_axi_rresp, s_axi_rdata};
      if (ha) last_t = cyc;
      @(posedge clk_sys);
      if (ha) s_axi_arvalid <= 1'b0;
      if (hr) return;
    end
    hang();
  endtask

  task automatic rc(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [33:0] v;
    rd(a, v);
    chk(v, {er, ed});
  endtask

  // ********************************************************
  // Tests
  // ********************************************************
  initial begin
    logic [33:0] v1, v2;
    logic [31:0] m;
    int t1;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rc(aon_regs_pkg::ADDR_PWR_SW, 32'h0000_00d8, 2'b00);
    rc(aon_regs_pkg::ADDR_DROP, 32'h0000_0075, 2'b00);
    rc(aon_regs_pkg::ADDR_CONV, 32'h0000_0001, 2'b00);
    rc(aon_regs_pkg::ADDR_THR, 32'h0, 2'b00);
    rc(aon_regs_pkg::ADDR_WAKE, 32'h0, 2'b00);
    rc(aon_regs_pkg::ADDR_WDOG, 32'h0, 2'b00);
    rc(aon_regs_pkg::ADDR_TUNE, 32'h0b03_1710, 2'b00);
    $display("Test reset_values done");
    wc(aon_regs_pkg::ADDR_TUNE, 32'hffff_ffff, 2'b00);
    rc(aon_regs_pkg::ADDR_TUNE, 32'h3f3f_fff3, 2'b00);
    chk({4'h0, tune_o}, 34'h0_3f3f_fff3);
    wc(aon_regs_pkg::ADDR_PWR_SW, 32'hffff_ffff, 2'b00);
    rc(aon_regs_pkg::ADDR_PWR_SW, 32'h0000_03fd, 2'b00);
    wc(aon_regs_pkg::ADDR_PWR_SW, 32'h0, 2'b00);
    rc(aon_regs_pkg::ADDR_PWR_SW, 32'h0, 2'b00);
    wc(aon_regs_pkg::ADDR_DROP, 32'hffff_ffff, 2'b00);
    brown_event <= 1'b1;
    rc(aon_regs_pkg::ADDR_DROP, 32'h0000_5fff, 2'b00);
    brown_event <= 1'b0;
    black_event <= 1'b1;
    rc(aon_regs_pkg::ADDR_DROP, 32'h0000_3fff, 2'b00);
    black_event <= 1'b0;
    wc(aon_regs_pkg::ADDR_DROP, 32'h0000_1000, 2'b00);
    rc(aon_regs_pkg::ADDR_DROP, 32'h0000_1000, 2'b00);
    for (int i = 0; i < 4; i++) begin
      m = {16'h0, i[1:0], 10'h2aa, i[1:0], 2'b10};
      wc(aon_regs_pkg::ADDR_CONV, m, 2'b00);
      rc(aon_regs_pkg::ADDR_CONV, m, 2'b00);
      m = {2'b11, i[1:0], 12'hf0f, 2'b11, ~i[1:0], 12'h0f0};
      wc(aon_regs_pkg::ADDR_THR, m, 2'b00);
      rc(aon_regs_pkg::ADDR_THR, {2'b00, m[29:0]}, 2'b00);
      chk({4'h0, thr_o}, {4'h0, m[29:0]});
    end
    wc(aon_regs_pkg::ADDR_WDOG, 32'hffff_ffff, 2'b00);
    rc(aon_regs_pkg::ADDR_WDOG, 32'h0000_001f, 2'b00);
    wc(aon_regs_pkg::ADDR_WDOG, 32'h0, 2'b00);
    wc(32'h5009_1024, 32'hffff_ffff, 2'b10);
    rc(32'h5009_1024, 32'h0, 2'b10);
    $display("Test writable_fields done");
    ready_in <= 7'b1010101;
    ext_wake_level <= 1'b1;
    rc(aon_regs_pkg::ADDR_READY, 32'h0000_2a09, 2'b00);
    ready_in <= 7'b0101010;
    ext_wake_level <= 1'b0;
    wc(aon_regs_pkg::ADDR_READY, 32'hffff_ffff, 2'b00);
    rc(aon_regs_pkg::ADDR_READY, 32'h0000_1500, 2'b00);
    rd(aon_regs_pkg::ADDR_CNT_LO, v1);
    t1 = last_t;
    wc(aon_regs_pkg::ADDR_CNT_LO, 32'h0, 2'b00);
    wc(aon_regs_pkg::ADDR_CNT_HI, 32'hf, 2'b00);
    rd(aon_regs_pkg::ADDR_CNT_LO, v2);
    chk(v2 - v1, 34'(last_t - t1));
    rc(aon_regs_pkg::ADDR_CNT_HI, 32'h0, 2'b00);
    $display("Test status_and_counter done");
    sensor_wake_pins <= 4'ha;
    wake_evt <= 7'h7f;
    @(posedge clk_sys);
    wake_evt <= 7'h00;
    m = 32'h0000_0a7f;
    rc(aon_regs_pkg::ADDR_WAKE, m, 2'b00);
    for (int i = 0; i < 7; i++) begin
      wc(aon_regs_pkg::ADDR_WAKE, 32'h0, 2'b00);
      rc(aon_regs_pkg::ADDR_WAKE, m, 2'b00);
      m[i] = 1'b0;
      wc(aon_regs_pkg::ADDR_WAKE, 32'h1 << i, 2'b00);
      rc(aon_regs_pkg::ADDR_WAKE, m, 2'b00);
    end
    sensor_wake_pins <= 4'h5;
    for (int j = 0; j < 5; j++) begin
      ext_wake_pins <= 5'h01 << j;
      @(posedge clk_sys);
      ext_wake_pins <= 5'h00;
      rc(aon_regs_pkg::ADDR_WAKE, 32'h0000_0501, 2'b00);
      wc(aon_regs_pkg::ADDR_WAKE, 32'h0000_0001, 2'b00);
    end
    $display("Test wake_flags done");
    // One rising edge of counter bit 14 per 32768 cycles at tap 0
    for (int e = 1; e >= 0; e--) begin
      wdog_count_en <= e[0];
      rd(aon_regs_pkg::ADDR_WDOG, v1);
      t1 = last_t;
      while (cyc < t1 + 32767) begin
        @(negedge clk_sys);
      end
      @(posedge clk_sys);
      rd(aon_regs_pkg::ADDR_WDOG, v2);
      chk({32'h0, v2[6:5]}, {32'h0, v1[6:5] + e[1:0]});
      chk({32'h0, wcnt_o}, {32'h0, v2[6:5]});
    end
    $display("Test watchdog_count done");
    report_and_stop();
  end
endmodule
